// ---- rtl/sfcs_pkg.sv ----
// package: constants for the simd fp control/status block
package sfcs_pkg;
    localparam int unsigned SFCS_CSR_W = 32;
    localparam int unsigned SFCS_VEC_W = 128;
    localparam int unsigned SFCS_VEC_N = 8;
    localparam int unsigned SFCS_VIDX_W = 3;
    // control/status field positions
    localparam int unsigned SFCS_FLAG_LO = 0;
    localparam int unsigned SFCS_FLAG_HI = 5;
    localparam int unsigned SFCS_DAZ_BIT = 6;
    localparam int unsigned SFCS_MASK_LO = 7;
    localparam int unsigned SFCS_MASK_HI = 12;
    localparam int unsigned SFCS_RND_LO = 13;
    localparam int unsigned SFCS_RND_HI = 14;
    localparam int unsigned SFCS_FTZ_BIT = 15;
    localparam logic [31:0] SFCS_CSR_RESET = 32'h0000_1F80;
    localparam logic [31:0] SFCS_WMASK_NODAZ = 32'h0000_FFBF;
    localparam logic [31:0] SFCS_WMASK_DAZ = 32'h0000_FFFF;
    // identify query leaf 1 result bits
    localparam int unsigned SFCS_ID_SAVE_BIT = 24;
    localparam int unsigned SFCS_ID_EXT1_BIT = 25;
    localparam int unsigned SFCS_ID_EXT2_BIT = 26;
    localparam logic [31:0] SFCS_ID_LEAF1 = 32'h0000_0001;
    // control register bit positions
    localparam int unsigned SFCS_FPU_EMULATION_BIT_BIT = 2;
    localparam int unsigned SFCS_NUMERIC_ERROR_REPORT_BIT_BIT = 5;
    localparam int unsigned SFCS_CR4_SAVE_BIT = 9;
    localparam int unsigned SFCS_CR4_EXC_BIT = 10;
    // fault codes
    typedef enum logic [3:0] {
        SFCS_FLT_NONE = 4'h0,
        SFCS_FLT_UD = 4'h1,
        SFCS_FLT_GP = 4'h2,
        SFCS_FLT_XF = 4'h4
    } sfcs_fault_e;
endpackage

// ---- rtl/sfcs_state.sv ----
// module: simd fp control/status register and vector register bank
// Functional notes
// RQ1 - simd faults never drive numeric error out
// RQ2 - ignore numeric error input has no effect
// RQ3 - simd flags and masks kept apart from x87
// RQ4 - rounding fields of simd and x87 independent
// RQ5 - unmasking a set flag raises no fault
// RQ6 - software should keep flush-to-zero at zero
// RQ7 - identify leaf 1 reports extensions, bits 25,26
// RQ8 - identify leaf 1 bit 24 reports state save
// RQ9 - os sets save and exception enable bits
// RQ10 - software checks emulation bit is zero
// RQ11 - unsupported simd instruction raises invalid opcode
// RQ12 - saved write mask zero or bit 6 set
// RQ13 - setting unsupported daz bit raises protection fault
// RQ14 - reset sets six exception mask bits
// RQ15 - reset clears six sticky flag bits
// RQ16 - reset loads rounding field with nearest
// RQ17 - reset clears flush-to-zero bit
// RQ18 - reset clears denormal-as-zero bit
// RQ19 - reset zeroes vectors, csr becomes 1F80
// RQ20 - soft init leaves vectors and csr unchanged
// RQ21 - unmasked exception without os enable: invalid opcode
// RQ22 - write setting reserved bits rejected, no change
`timescale 1ns/1ps
`default_nettype none
module sfcs_state
    import sfcs_pkg::*;
#(
    parameter bit HAS_DAZ = 1'b1,
    parameter bit HAS_EXT1 = 1'b1,
    parameter bit HAS_EXT2 = 1'b1,
    parameter bit HAS_SAVE = 1'b1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // soft init pin, leaves state untouched
    input wire logic soft_init,
    // x87 side pins
    input wire logic ignore_numeric_error_in,
    input wire logic x87_error_in,
    output logic numeric_error_out,
    // control register bits
    input wire logic fpu_emulation_bit,
    input wire logic numeric_error_report_bit,
    input wire logic os_state_save_enable,
    input wire logic os_simd_exception_enable,
    // control/status write and read
    input wire logic csr_wr,
    input wire logic [31:0] csr_wdata,
    output logic [31:0] simd_fp_control_status,
    output logic [31:0] control_write_mask,
    // vector register access
    input wire logic vec_wr,
    input wire logic [SFCS_VIDX_W-1:0] vec_idx,
    input wire logic [SFCS_VEC_W-1:0] vec_wdata,
    output logic [SFCS_VEC_W-1:0] vec_rdata,
    // instruction issue and exception report
    input wire logic simd_issue,
    input wire logic simd_ext2,
    input wire logic simd_needs_save,
    input wire logic exc_valid,
    input wire logic [5:0] exc_flags,
    // identify query
    input wire logic id_req,
    input wire logic [31:0] id_leaf,
    output logic [31:0] id_result,
    // fault and rounding outputs
    output logic [3:0] fault,
    output logic fault_valid,
    output logic [1:0] simd_round_mode
);
    // csr fields, one register each
    logic [5:0] flags_r;
    logic [5:0] masks_r;
    logic daz_r;
    logic [1:0] rnd_r;
    logic ftz_r;
    logic [31:0] csr_r;
    // vector bank
    logic [SFCS_VEC_W-1:0] vec_r [SFCS_VEC_N];
    logic [SFCS_VEC_N-1:0] vec_we;
    // write side
    logic [31:0] wmask;
    logic wr_take;
    logic wr_ok;
    logic wr_load;
    // instruction side
    logic op_take;
    logic ext_missing;
    logic emu_on;
    logic save_missing;
    logic op_refused;
    logic exc_take;
    logic [5:0] unmasked;
    logic unmasked_hit;
    logic [3:0] fault_nxt;
    // identify and pin side
    logic [31:0] id_nxt;
    logic id_is_leaf1;
    logic numeric_error_nxt;
    logic unused_ok;

    // elaboration checks on the layout constants
    if (SFCS_VEC_N != (1 << SFCS_VIDX_W)) begin : g_bad_vec_count
        $error("vector count and index width disagree");
    end
    if (SFCS_CSR_W != 32) begin : g_bad_csr_width
        $error("control/status register must be 32 bits");
    end
    if (SFCS_FLAG_HI - SFCS_FLAG_LO != 5) begin : g_bad_flag_field
        $error("flag field must hold six bits");
    end
    if (SFCS_MASK_HI - SFCS_MASK_LO != 5) begin : g_bad_mask_field
        $error("mask field must hold six bits");
    end
    if (SFCS_RND_HI - SFCS_RND_LO != 1) begin : g_bad_round_field
        $error("rounding field must hold two bits");
    end
    if (SFCS_FLAG_HI + 1 != SFCS_DAZ_BIT ||
            SFCS_DAZ_BIT + 1 != SFCS_MASK_LO ||
            SFCS_MASK_HI + 1 != SFCS_RND_LO ||
            SFCS_RND_HI + 1 != SFCS_FTZ_BIT) begin : g_bad_field_order
        $error("control/status fields must be contiguous");
    end
    if (SFCS_CSR_RESET[31:16] != 16'h0000) begin : g_bad_reset_value
        $error("reset value sets reserved bits");
    end
    if (SFCS_WMASK_NODAZ[SFCS_DAZ_BIT] ||
            !SFCS_WMASK_DAZ[SFCS_DAZ_BIT]) begin : g_bad_wmask_daz
        $error("write masks disagree on the denormal bit");
    end
    if (SFCS_WMASK_DAZ[31:16] != 16'h0000 ||
            SFCS_WMASK_NODAZ[31:16] != 16'h0000) begin : g_bad_wmask_top
        $error("write masks allow reserved upper bits");
    end
    if (SFCS_ID_SAVE_BIT > 31 || SFCS_ID_EXT1_BIT > 31 ||
            SFCS_ID_EXT2_BIT > 31) begin : g_bad_id_bits
        $error("identify bits outside the result word");
    end

    // clears the bits that the write mask leaves out
    function automatic logic [31:0] reserved_clear(input logic [31:0] v,
            input logic [31:0] m);
        reserved_clear = v & m;
    endfunction

    // one-hot select of a vector register
    function automatic logic [SFCS_VEC_N-1:0] vec_onehot(
            input logic [SFCS_VIDX_W-1:0] idx);
        vec_onehot = '0;
        vec_onehot[idx] = 1'b1;
    endfunction

    // write side of the control/status register
    assign wmask = HAS_DAZ ? SFCS_WMASK_DAZ : SFCS_WMASK_NODAZ;
    assign wr_take = csr_wr && !simd_issue;
    assign wr_ok = (reserved_clear(csr_wdata, wmask) == csr_wdata); // [RQ13]
    assign wr_load = wr_take && wr_ok; // [RQ22]

    // instruction side checks
    assign op_take = simd_issue;
    assign ext_missing = simd_ext2 ? !HAS_EXT2 : !HAS_EXT1; // [RQ11]
    assign emu_on = fpu_emulation_bit;
    assign save_missing = simd_needs_save && !os_state_save_enable;
    assign op_refused = ext_missing || emu_on || save_missing; // [RQ11]
    assign exc_take = op_take && exc_valid;
    assign unmasked = exc_flags & ~masks_r; // [RQ5]
    assign unmasked_hit = exc_take && (unmasked != 6'h00); // [RQ5]

    // fault decode, invalid opcode first
    always_comb begin
        fault_nxt = SFCS_FLT_NONE;
        if (op_take) begin
            if (op_refused) begin
                fault_nxt = SFCS_FLT_UD; // [RQ11]
            end else if (unmasked_hit) begin
                if (os_simd_exception_enable) begin
                    fault_nxt = SFCS_FLT_XF; // [RQ3]
                end else begin
                    fault_nxt = SFCS_FLT_UD; // [RQ21]
                end
            end
        end else if (csr_wr && !wr_ok) begin
            fault_nxt = SFCS_FLT_GP; // [RQ13] [RQ22]
        end
    end

    // sticky flags and masks, one bit per exception kind
    for (genvar g = 0; g < 6; g++) begin : g_exc
        always_ff @(posedge sys_clk or negedge rst_b) begin
            if (!rst_b) begin
                flags_r[g] <= SFCS_CSR_RESET[SFCS_FLAG_LO + g]; // [RQ15]
            end else if (exc_take && exc_flags[g]) begin
                flags_r[g] <= 1'b1; // [RQ3]
            end else if (wr_load) begin
                flags_r[g] <= csr_wdata[SFCS_FLAG_LO + g];
            end
        end
        always_ff @(posedge sys_clk or negedge rst_b) begin
            if (!rst_b) begin
                masks_r[g] <= SFCS_CSR_RESET[SFCS_MASK_LO + g]; // [RQ14]
            end else if (wr_load) begin
                masks_r[g] <= csr_wdata[SFCS_MASK_LO + g]; // [RQ5]
            end
        end
    end

    // denormal-as-zero bit, held at zero when absent
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            daz_r <= SFCS_CSR_RESET[SFCS_DAZ_BIT]; // [RQ18]
        end else if (wr_load && HAS_DAZ) begin
            daz_r <= csr_wdata[SFCS_DAZ_BIT]; // [RQ13]
        end
    end

    // rounding field, private to the simd side
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rnd_r <= SFCS_CSR_RESET[SFCS_RND_HI:SFCS_RND_LO]; // [RQ16]
        end else if (wr_load) begin
            rnd_r <= csr_wdata[SFCS_RND_HI:SFCS_RND_LO]; // [RQ4]
        end
    end

    // flush-to-zero control
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ftz_r <= SFCS_CSR_RESET[SFCS_FTZ_BIT]; // [RQ17]
        end else if (wr_load) begin
            ftz_r <= csr_wdata[SFCS_FTZ_BIT];
        end
    end

    // assembled register, reserved bits read as zero
    // soft init reaches none of the fields [RQ20]
    assign csr_r = {16'h0000, ftz_r, rnd_r, masks_r, daz_r, flags_r}; // [RQ19]

    // vector registers, soft init has no path in [RQ20]
    assign vec_we = vec_wr ? vec_onehot(vec_idx) : '0;
    for (genvar v = 0; v < SFCS_VEC_N; v++) begin : g_vec
        always_ff @(posedge sys_clk or negedge rst_b) begin
            if (!rst_b) begin
                vec_r[v] <= '0; // [RQ19]
            end else if (vec_we[v]) begin
                vec_r[v] <= vec_wdata;
            end
        end
    end

    // identify query answer
    assign id_is_leaf1 = (id_leaf == SFCS_ID_LEAF1);
    always_comb begin
        id_nxt = 32'h0000_0000;
        if (id_is_leaf1) begin
            id_nxt[SFCS_ID_SAVE_BIT] = HAS_SAVE; // [RQ8]
            id_nxt[SFCS_ID_EXT1_BIT] = HAS_EXT1; // [RQ7]
            id_nxt[SFCS_ID_EXT2_BIT] = HAS_EXT2; // [RQ7]
        end
    end

    // numeric error pin sees only the x87 side
    assign numeric_error_nxt = x87_error_in &&
        !numeric_error_report_bit; // [RQ1]

    // control/status readback and rounding output
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            simd_fp_control_status <= SFCS_CSR_RESET;
            simd_round_mode <= SFCS_CSR_RESET[SFCS_RND_HI:SFCS_RND_LO];
        end else begin
            simd_fp_control_status <= csr_r;
            simd_round_mode <= rnd_r; // [RQ4]
        end
    end

    // saved write mask, zero when the bit is absent
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            control_write_mask <= 32'h0000_0000;
        end else begin
            control_write_mask <= HAS_DAZ ? wmask : 32'h0000_0000; // [RQ12]
        end
    end

    // vector read port
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            vec_rdata <= '0;
        end else begin
            vec_rdata <= vec_r[vec_idx];
        end
    end

    // fault report, registered one cycle after the decode
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            fault <= SFCS_FLT_NONE;
            fault_valid <= 1'b0;
        end else begin
            fault <= fault_nxt;
            fault_valid <= (fault_nxt != SFCS_FLT_NONE);
        end
    end

    // numeric error pin, ignore pin has no say [RQ2]
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            numeric_error_out <= 1'b0;
        end else begin
            numeric_error_out <= numeric_error_nxt; // [RQ1]
        end
    end

    // identify result, held until the next query
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            id_result <= 32'h0000_0000;
        end else if (id_req) begin
            id_result <= id_nxt;
        end
    end

    // pins that must not touch any state [RQ2] [RQ20]
    assign unused_ok = ignore_numeric_error_in & soft_init;
endmodule // sfcs_state
`default_nettype wire

// ---- dv/sfcs_state_monitor.sv ----
// checker: port assertions for the simd fp control/status block
`timescale 1ns/1ps
`default_nettype none
module sfcs_state_monitor (
    input wire logic sys_clk, rst_b, x87_error_in, numeric_error_out,
    input wire logic fpu_emulation_bit, numeric_error_report_bit,
    input wire logic os_state_save_enable, os_simd_exception_enable,
    input wire logic csr_wr, simd_issue, exc_valid, id_req, fault_valid,
    input wire logic simd_needs_save,
    input wire logic [31:0] csr_wdata, simd_fp_control_status,
    input wire logic [31:0] control_write_mask, id_leaf, id_result,
    input wire logic [5:0] exc_flags,
    input wire logic [3:0] fault
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    logic [31:0] m;
    logic bad;
    logic unm;
    assign m = control_write_mask == 0 ? 32'h0000FFBF : control_write_mask;
    assign bad = csr_wr && !simd_issue && |(csr_wdata & ~m);
    assign unm = |(exc_flags & ~simd_fp_control_status[12:7]);
    property p_numeric_error_out; $past(rst_b) |-> numeric_error_out ==
        ($past(x87_error_in) && !$past(numeric_error_report_bit)); endproperty
    a_numeric_error_out: assert property (p_numeric_error_out)
        else $error("error pin not from x87 side");
    property p_rst; $rose(rst_b) |-> simd_fp_control_status == 32'h1F80;
    endproperty
    a_rst: assert property (p_rst) else $error("bad reset value");
    property p_gp; bad |=> fault_valid && fault == 4'h2; endproperty
    a_gp: assert property (p_gp) else $error("no protection fault");
    property p_hold; bad |-> ##2 $stable(simd_fp_control_status); endproperty
    a_hold: assert property (p_hold) else $error("refused write landed");
    property p_wr; csr_wr && !simd_issue && !bad |->
        ##2 simd_fp_control_status == $past(csr_wdata, 2); endproperty
    a_wr: assert property (p_wr) else $error("write not stored");
    property p_xf; simd_issue && exc_valid && unm && !fpu_emulation_bit &&
        (os_state_save_enable || !simd_needs_save) && !$past(csr_wr) &&
        !$past(csr_wr, 2) |=> fault ==
        ($past(os_simd_exception_enable) ? 4'h4 : 4'h1);
    endproperty
    a_xf: assert property (p_xf) else $error("wrong exception fault");
    property p_ud; simd_issue && fpu_emulation_bit |=> fault == 4'h1;
    endproperty
    a_ud: assert property (p_ud) else $error("no invalid opcode");
    property p_id; id_req && id_leaf == 32'h1 |=> id_result[26:24] == 3'h7;
    endproperty
    a_id: assert property (p_id) else $error("feature bits missing");
    property p_mask; $past(rst_b) |->
        control_write_mask == 32'h0 || control_write_mask[6];
    endproperty
    a_mask: assert property (p_mask) else $error("bad write mask");
    c_gp: cover property (fault_valid && fault == 4'h2);
    c_xf: cover property (fault_valid && fault == 4'h4);
    c_id: cover property (id_req);
endmodule // sfcs_state_monitor
bind sfcs_state sfcs_state_monitor mon_u (.*);
`default_nettype wire

// ---- dv/sfcs_state_test.sv ----
// bench: self-checking test of the simd fp control/status block
`timescale 1ns/1ps
`default_nettype none
module sfcs_state_test;
    import sfcs_pkg::*;
    logic sys_clk = 0, rst_b = 0, soft_init = 0, ignore_numeric_error_in = 0;
    logic x87_error_in = 0, numeric_error_out, fpu_emulation_bit = 0;
    logic numeric_error_report_bit = 0, os_state_save_enable = 1;
    logic os_simd_exception_enable = 1, csr_wr = 0, vec_wr = 0, simd_issue = 0;
    logic simd_ext2 = 0, simd_needs_save = 0, exc_valid = 0, id_req = 0;
    logic fault_valid;
    logic [31:0] csr_wdata = 0, simd_fp_control_status, control_write_mask;
    logic [31:0] id_leaf = 0, id_result, w;
    logic [2:0] vec_idx = 0;
    logic [127:0] vec_wdata = 0, vec_rdata;
    logic [5:0] exc_flags = 0;
    logic [3:0] fault;
    logic [1:0] simd_round_mode;
    int n_errors = 0, cmp_count = 0, cyc = 0;
    sfcs_state #(.HAS_DAZ(1'b0)) dut_u (.*);
    initial forever #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (++cyc > 3000) begin
        n_errors++;
        tally_and_finish();
    end
    task automatic step(int n = 1);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(logic [127:0] g, e);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic wr(logic [31:0] d);
        csr_wr = 1;
        csr_wdata = d;
        step();
        csr_wr = 0;
    endtask
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        void'($urandom(4821));
        step(8);
        rst_b = 1;
        step(2);
        chk(simd_fp_control_status, 32'h1F80);
        chk(control_write_mask, 32'h0);
        for (int i = 0; i < 8; i++) begin
            vec_idx = i[2:0];
            step();
            chk(vec_rdata, 128'h0);
        end
        w = $urandom;
        vec_wr = 1;
        vec_wdata = {4{w}};
        step();
        vec_wr = 0;
        soft_init = 1;
        step(4);
        soft_init = 0;
        chk(vec_rdata, {4{w}});
        chk(simd_fp_control_status, 32'h1F80);
        id_req = 1;
        id_leaf = 32'h1;
        step();
        id_req = 0;
        chk(id_result[26:24], 3'h7);
        $display("reset, init and identify done");
        for (int i = 0; i < 6; i++) begin
            wr(i == 0 ? 32'h0000_1FC0 : $urandom | 32'h0001_0000);
            chk({fault_valid, fault}, 5'h12);
            step();
            chk(simd_fp_control_status, 32'h1F80);
        end
        repeat (6) begin
            w = $urandom & 32'h0000_7FBF;
            wr(w);
            chk(fault_valid, 1'b0);
            step();
            chk(simd_fp_control_status, w);
            chk(simd_round_mode, w[14:13]);
        end
        $display("register writes done");
        wr(32'h0000_1F01);
        chk(fault_valid, 1'b0);
        step(2);
        for (int k = 2; k >= 0; k--) begin
            os_simd_exception_enable = k[0];
            fpu_emulation_bit = k == 0;
            {simd_issue, exc_valid, exc_flags} = 8'hC1;
            step();
            {simd_issue, exc_valid} = 2'b0;
            chk(fault, k == 1 ? 4'h4 : 4'h1);
            chk(numeric_error_out, 1'b0);
        end
        fpu_emulation_bit = 0;
        repeat (40) begin
            {x87_error_in, ignore_numeric_error_in, numeric_error_report_bit} =
                3'($urandom);
            step();
            chk(numeric_error_out,
                x87_error_in & ~numeric_error_report_bit);
        end
        $display("exceptions and pins done");
        tally_and_finish();
    end
endmodule // sfcs_state_test
`default_nettype wire
